/* File: common/led_disp_pkg.sv */
// Purpose: Shared constants and types for the eight-digit LED display driver.
// Assumes: A 25 MHz system clock.
// Notes:   Control byte fields follow the input line order, line 7 down to line 0.
package led_disp_pkg;
    localparam int unsigned CLK_HZ        = 25_000_000;
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned DIGITS        = 8;
    localparam int unsigned SCAN_RATE_HZ  = 390;
    localparam int unsigned BLANK_GAP_NS  = 10_000;
    localparam int unsigned BLANK_MIN_NS  = 2_000;
    localparam int unsigned BLANK_CYC     = (BLANK_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned BLANK_MIN_CYC = (BLANK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SLOT_CYC      = CLK_HZ / (SCAN_RATE_HZ * DIGITS);
    localparam int unsigned CNT_W         = 16;
    localparam int unsigned DP_BIT        = 7;
    localparam logic [2:0]  RST_ADDR      = 3'h0;

    typedef logic [7:0] byte_t;
    typedef logic [6:0] seg_t;

    typedef struct packed {
        logic       update_announce;
        logic       scheme_select;
        logic       decode_sel;
        logic       power_sel;
        logic       bank_sel;
        logic [2:0] digit_addr;
    } ctrl_t;

    localparam ctrl_t CTRL_RST = '{update_announce: 1'b0, scheme_select: 1'b0,
                                   decode_sel: 1'b0, power_sel: 1'b1,
                                   bank_sel: 1'b1, digit_addr: RST_ADDR};

    typedef enum logic {ST_BLANK = 1'b0, ST_DRIVE = 1'b1} scan_state_t;
endpackage : led_disp_pkg

/* File: rtl/led_display.sv */
// Purpose: Write port, display RAM and multiplex scanner of an eight-digit LED driver.
// Assumes: All pins except rst are asynchronous to mclk and are synchronised here.
// Notes:   A write strobe must stay low and high for several mclk periods to be seen.
`timescale 1ns/1ps
module led_display
    import led_disp_pkg::*;
#(
    parameter int unsigned SLOT_CYCLES   = SLOT_CYC,
    parameter bit          RANDOM_ACCESS = 1'b0
)
(
    input  wire logic                  mclk,
    input  wire logic                  rst,
    input  wire led_disp_pkg::byte_t   in_lines,
    input  wire logic                  write_strobe,
    input  wire logic                  mode,
    input  wire logic [2:0]            ra_digit_addr,
    input  wire logic                  tri_level_high,
    input  wire logic                  tri_level_low,
    output led_disp_pkg::seg_t         seg_out,
    output logic                       decimal_point_out,
    output logic [7:0]                 digit_drive,
    output logic                       seq_active
);
    import led_disp_pkg::*;

    localparam int unsigned PIN_W = 15;
    // Stages reset with the strobe at its idle high level, so leaving reset shows no false edge.
    localparam logic [PIN_W-1:0] PIN_RST = 15'h0100;

    logic [PIN_W-1:0] pin_s1;
    logic [PIN_W-1:0] pin_s2;
    logic             wr_prev;
    ctrl_t            ctrl;
    byte_t            ram [2*DIGITS];
    logic [2:0]       seq_idx;
    scan_state_t      state;
    logic [CNT_W-1:0] cnt;
    logic [2:0]       digit;

    byte_t            data_s;
    logic             wr_s;
    logic             mode_s;
    logic             wr_evt;
    logic             ram_we;
    logic [3:0]       wr_idx;
    ctrl_t            next_ctrl;
    logic [2:0]       next_seq_idx;
    logic             next_seq_active;
    logic             eff_power;
    logic             eff_scheme;
    logic             eff_nodecode;
    logic             eff_bank;
    scan_state_t      next_state;
    logic [CNT_W-1:0] next_cnt;
    logic [2:0]       next_digit;
    byte_t            cur_byte;
    seg_t             dec_seg;
    seg_t             next_seg;
    logic             next_dp;
    logic [7:0]       next_drive;

    // The second stage alone feeds logic, so a metastable first stage is never observed.
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            pin_s1  <= PIN_RST;
            pin_s2  <= PIN_RST;
            wr_prev <= 1'b1;
        end
        else
        begin
            pin_s1  <= {tri_level_low, tri_level_high, ra_digit_addr, mode, write_strobe, in_lines};
            pin_s2  <= pin_s1;
            wr_prev <= wr_s;
        end
    end

    assign data_s = pin_s2[7:0];
    assign wr_s   = pin_s2[8];
    assign mode_s = pin_s2[9];
    assign wr_evt = wr_s & ~wr_prev;

    always_comb
    begin
        if (RANDOM_ACCESS)
        begin
            eff_power    = ~pin_s2[14];
            eff_scheme   = pin_s2[13];
            eff_nodecode = 1'b0;
        end
        else
        begin
            eff_power    = ctrl.power_sel;
            eff_scheme   = ctrl.scheme_select;
            eff_nodecode = ctrl.decode_sel;
        end
        eff_bank = eff_nodecode ? 1'b1 : ctrl.bank_sel;
    end

    always_comb
    begin
        next_ctrl       = ctrl;
        next_seq_idx    = seq_idx;
        next_seq_active = seq_active;
        ram_we          = 1'b0;
        wr_idx          = {~eff_bank, ctrl.digit_addr};
        if (RANDOM_ACCESS)
            wr_idx = {~eff_bank, pin_s2[12:10]};
        else if (seq_active)
            wr_idx = {~eff_bank, seq_idx};
        if (wr_evt)
        begin
            if (mode_s && !RANDOM_ACCESS)
            begin
                next_ctrl       = ctrl_t'(data_s);
                next_seq_active = data_s[7];
                next_seq_idx    = 3'h0;
            end
            else
            begin
                ram_we = 1'b1;
                if (seq_active && !RANDOM_ACCESS)
                begin
                    next_seq_idx    = 3'(seq_idx + 3'h1);
                    next_seq_active = (seq_idx != 3'h7);
                end
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            ctrl       <= CTRL_RST;
            seq_idx    <= 3'h0;
            seq_active <= 1'b0;
        end
        else
        begin
            ctrl       <= next_ctrl;
            seq_idx    <= next_seq_idx;
            seq_active <= next_seq_active;
        end
    end

    // RAM holds no reset so it maps onto plain storage; contents are undefined until written.
    always_ff @(posedge mclk)
    begin
        if (ram_we)
            ram[wr_idx] <= data_s;
    end

    always_comb
    begin
        next_state = state;
        next_cnt   = cnt;
        next_digit = digit;
        if (!eff_power)
        begin
            next_state = ST_BLANK;
            next_cnt   = CNT_W'(BLANK_CYC - 1);
        end
        else if (cnt != '0)
            next_cnt = CNT_W'(cnt - 1'b1);
        else
        begin
            case (state)
                ST_BLANK:
                begin
                    next_state = ST_DRIVE;
                    next_cnt   = CNT_W'(SLOT_CYCLES - BLANK_CYC - 1);
                end
                ST_DRIVE:
                begin
                    next_state = ST_BLANK;
                    next_cnt   = CNT_W'(BLANK_CYC - 1);
                    next_digit = 3'(digit + 3'h1);
                end
                default:
                begin
                    next_state = ST_BLANK;
                    next_cnt   = CNT_W'(BLANK_CYC - 1);
                end
            endcase
        end
    end

    assign cur_byte = ram[{~eff_bank, next_digit}];

    seg_decoder u_dec
    (
        .nibble        (cur_byte[3:0]),
        .scheme_select (eff_scheme),
        .seg           (dec_seg)
    );

    always_comb
    begin
        next_drive = '0;
        next_seg   = '0;
        next_dp    = 1'b0;
        if (next_state == ST_DRIVE)
        begin
            next_drive = 8'(1) << next_digit;
            next_seg   = eff_nodecode ? cur_byte[6:0] : dec_seg;
            next_dp    = cur_byte[DP_BIT];
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            state             <= ST_BLANK;
            cnt               <= CNT_W'(BLANK_CYC - 1);
            digit             <= 3'h0;
            digit_drive       <= '0;
            seg_out           <= '0;
            decimal_point_out <= 1'b0;
        end
        else
        begin
            state             <= next_state;
            cnt               <= next_cnt;
            digit             <= next_digit;
            digit_drive       <= next_drive;
            seg_out           <= next_seg;
            decimal_point_out <= next_dp;
        end
    end

    // Counts dark cycles between digit activations; read only by the checks below.
    logic [CNT_W-1:0] gap_cnt;
    always_ff @(posedge mclk)
    begin
        if (rst)
            gap_cnt <= '0;
        else if (digit_drive != '0)
            gap_cnt <= '0;
        else if (gap_cnt != '1)
            gap_cnt <= CNT_W'(gap_cnt + 1'b1);
    end

    sequence s_ctrl_write;
        wr_evt && mode_s && !RANDOM_ACCESS;
    endsequence
    sequence s_announce;
        s_ctrl_write ##0 data_s[7];
    endsequence

    property p_ctrl_load;
        @(posedge mclk) disable iff (rst) s_ctrl_write |=> ctrl == ctrl_t'($past(data_s));
    endproperty
    a_ctrl_load: assert property (p_ctrl_load) else $error("control byte not loaded");

    property p_ram_load;
        @(posedge mclk) disable iff (rst) ram_we |=> ram[$past(wr_idx)] == $past(data_s);
    endproperty
    a_ram_load: assert property (p_ram_load) else $error("RAM byte not stored");

    property p_edge_only;
        @(posedge mclk) disable iff (rst) ram_we |-> wr_s && !wr_prev && !(mode_s && !RANDOM_ACCESS);
    endproperty
    a_edge_only: assert property (p_edge_only) else $error("RAM written off the edge");

    property p_seq_start;
        @(posedge mclk) disable iff (rst) s_announce |=> seq_active && seq_idx == 3'h0;
    endproperty
    a_seq_start: assert property (p_seq_start) else $error("sequence not armed");

    property p_seq_step;
        @(posedge mclk) disable iff (rst)
            ram_we && seq_active |-> wr_idx[2:0] == seq_idx
            ##1 (seq_idx == 3'($past(seq_idx) + 3'h1)) && (seq_active == ($past(seq_idx) != 3'h7));
    endproperty
    a_seq_step: assert property (p_seq_step) else $error("sequence step wrong");

    property p_single_addr;
        @(posedge mclk) disable iff (rst)
            ram_we && !seq_active && !RANDOM_ACCESS |-> wr_idx[2:0] == ctrl.digit_addr;
    endproperty
    a_single_addr: assert property (p_single_addr) else $error("single digit address");

    property p_bank;
        @(posedge mclk) disable iff (rst)
            ram_we && !eff_nodecode |-> wr_idx[3] == !ctrl.bank_sel;
    endproperty
    a_bank: assert property (p_bank) else $error("bank select ignored");

    property p_one_digit;
        @(posedge mclk) disable iff (rst) $onehot0(digit_drive);
    endproperty
    a_one_digit: assert property (p_one_digit) else $error("digit drives overlap");

    property p_blank_gap;
        @(posedge mclk) disable iff (rst)
            $changed(digit_drive) && digit_drive != '0 |-> gap_cnt >= CNT_W'(BLANK_CYC);
    endproperty
    a_blank_gap: assert property (p_blank_gap) else $error("blanking too short");

    property p_shutdown;
        @(posedge mclk) disable iff (rst) !eff_power |=> digit_drive == '0 && seg_out == '0;
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("display lit in shutdown");

    property p_nodecode;
        @(posedge mclk) disable iff (rst)
            next_state == ST_DRIVE && eff_nodecode |=> seg_out == $past(cur_byte[6:0])
            && decimal_point_out == $past(cur_byte[7]);
    endproperty
    a_nodecode: assert property (p_nodecode) else $error("no-decode segments wrong");
endmodule : led_display

/* File: rtl/seg_decoder.sv */
// Purpose: Seven-segment decoder for hexadecimal and Code B schemes.
// Assumes: Segment order {g,f,e,d,c,b,a}, active high.
// Notes:   Purely combinational.
`timescale 1ns/1ps
module seg_decoder
    import led_disp_pkg::*;
(
    input  wire logic [3:0]         nibble,
    input  wire logic               scheme_select,
    output led_disp_pkg::seg_t      seg
);
    always_comb
    begin
        case (nibble)
            4'h0: seg = 7'h3f;
            4'h1: seg = 7'h06;
            4'h2: seg = 7'h5b;
            4'h3: seg = 7'h4f;
            4'h4: seg = 7'h66;
            4'h5: seg = 7'h6d;
            4'h6: seg = 7'h7d;
            4'h7: seg = 7'h07;
            4'h8: seg = 7'h7f;
            4'h9: seg = 7'h6f;
            4'ha: seg = scheme_select ? 7'h77 : 7'h40;
            4'hb: seg = scheme_select ? 7'h7c : 7'h79;
            4'hc: seg = scheme_select ? 7'h39 : 7'h76;
            4'hd: seg = scheme_select ? 7'h5e : 7'h38;
            4'he: seg = scheme_select ? 7'h79 : 7'h73;
            4'hf: seg = scheme_select ? 7'h71 : 7'h00;
            default: seg = 7'h00;
        endcase
    end
endmodule : seg_decoder

/* File: verif/host_model.sv */
// Purpose: Behavioural host that writes control and display bytes to the driver.
// Assumes: The bench calls put_byte from a single process.
// Notes:   Lines no longer held show the inverse of the last byte.
`timescale 1ns/1ps
module host_model
    import led_disp_pkg::*;
(
    input  wire logic              mclk,
    output led_disp_pkg::byte_t    in_lines,
    output logic                   write_strobe,
    output logic                   mode
);
    initial
    begin
        in_lines     = 8'h00;
        write_strobe = 1'b1;
        mode         = 1'b0;
    end

    // The strobe stays low four cycles and data holds five more after it rises, to clear the synchroniser.
    task automatic put_byte(input logic m, input byte_t d);
        @(negedge mclk);
        mode         = m;
        in_lines     = d;
        write_strobe = 1'b0;
        repeat (4) @(negedge mclk);
        write_strobe = 1'b1;
        repeat (5) @(negedge mclk);
        in_lines     = ~d;
        mode         = ~m;
    endtask : put_byte
endmodule : host_model

/* File: verif/led_display_tb.sv */
// Purpose: Self-checking bench for the LED display write port and scanner.
// Assumes: A short slot of 300 cycles keeps the run brief.
// Notes:   The monitor compares each digit activation that finds a note queued with the oldest queued note.
`timescale 1ns/1ps
module led_display_tb;
    import led_disp_pkg::*;
    localparam int unsigned SLOT = 300;
    localparam seg_t HEX_T [0:15] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07,
                                      7'h7f, 7'h6f, 7'h77, 7'h7c, 7'h39, 7'h5e, 7'h79, 7'h71};
    localparam seg_t CODEB_T [0:15] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07,
                                        7'h7f, 7'h6f, 7'h40, 7'h79, 7'h76, 7'h38, 7'h73, 7'h00};
    logic        mclk;
    logic        rst;
    logic        write_strobe;
    logic        mode;
    logic        seq_active;
    logic        decimal_point_out;
    byte_t       in_lines;
    seg_t        seg_out;
    logic [7:0]  digit_drive;
    logic [7:0]  prev_dd;
    logic [15:0] e;
    logic [15:0] exp_q[$];
    logic [15:0] ra_q[$];
    byte_t       shown[8];
    byte_t       val[16];
    byte_t       ra_exp[8];
    byte_t       v;
    logic [2:0]  ra_addr;
    logic        tri_hi;
    logic        tri_lo;
    logic        ra_dp;
    seg_t        ra_seg;
    logic [7:0]  ra_dd;
    logic [7:0]  ra_prev;
    bit          ra_on;
    int          errors;
    int          tests_run;
    int          seed;
    int          since;
    int          dark;
    int          i;
    int          k;

    host_model host_u (.mclk(mclk), .in_lines(in_lines), .write_strobe(write_strobe),
                       .mode(mode));

    led_display #(.SLOT_CYCLES(SLOT), .RANDOM_ACCESS(1'b0)) dut_u (
        .mclk(mclk), .rst(rst), .in_lines(in_lines), .write_strobe(write_strobe),
        .mode(mode), .ra_digit_addr(3'h0), .tri_level_high(1'b0), .tri_level_low(1'b0),
        .seg_out(seg_out), .decimal_point_out(decimal_point_out),
        .digit_drive(digit_drive), .seq_active(seq_active));

    // The random-access copy shares the host lines and scans in step with dut_u until shutdown.
    led_display #(.SLOT_CYCLES(SLOT), .RANDOM_ACCESS(1'b1)) dut_ra_u (
        .mclk(mclk), .rst(rst), .in_lines(in_lines), .write_strobe(write_strobe),
        .mode(mode), .ra_digit_addr(ra_addr), .tri_level_high(tri_hi),
        .tri_level_low(tri_lo), .seg_out(ra_seg), .decimal_point_out(ra_dp),
        .digit_drive(ra_dd), .seq_active());

    initial mclk = 1'b0;
    always #20 mclk = ~mclk;

    task automatic check(input logic [31:0] seen, input logic [31:0] expct);
        tests_run++;
        if (seen !== expct)
        begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, expct);
        end
    endtask : check

    task automatic end_sim();
        $display("Counts: %0d comparisons, %0d errors", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_sim

    task automatic wait_dd(input logic [7:0] v);
        int n;
        n = 0;
        while (digit_drive !== v && n < 6000)
        begin
            @(negedge mclk);
            n++;
        end
        if (n == 6000)
        begin
            errors++;
            end_sim();
        end
    endtask : wait_dd

    // Notes are queued only once digit 8 goes dark, so the next activation is digit 1.
    task automatic scan_check();
        int n;
        wait_dd(8'h80);
        wait_dd(8'h00);
        for (int d = 0; d < 8; d++)
        begin
            exp_q.push_back({8'h01 << d, shown[d]});
            if (ra_on)
                ra_q.push_back({8'h01 << d, ra_exp[d]});
        end
        n = 0;
        while ((exp_q.size() > 0 || ra_q.size() > 0) && n < 3000)
        begin
            @(negedge mclk);
            n++;
        end
        if (n == 3000)
        begin
            errors++;
            end_sim();
        end
    endtask : scan_check

    function automatic byte_t ctl(input logic ann, input logic sch, input logic dec,
                                  input logic pwr, input logic bank, input logic [2:0] a);
        return {ann, sch, dec, pwr, bank, a};
    endfunction : ctl

    always @(negedge mclk)
    begin
        since++;
        if (digit_drive === 8'h00)
            dark++;
        else if (prev_dd === 8'h00)
        begin
            if (exp_q.size() > 0)
            begin
                e = exp_q.pop_front();
                check({digit_drive, decimal_point_out, seg_out}, e);
                check(since, SLOT);
                check(dark, BLANK_CYC);
            end
            since = 0;
            dark  = 0;
        end
        if (ra_dd !== 8'h00 && ra_prev === 8'h00 && ra_q.size() > 0)
        begin
            e = ra_q.pop_front();
            check({ra_dd, ra_dp, ra_seg}, e);
        end
        ra_prev = ra_dd;
        prev_dd = digit_drive;
    end

    initial
    begin
        seed      = 3;
        errors    = 0;
        tests_run = 0;
        since     = 0;
        dark      = 0;
        prev_dd   = 8'h00;
        ra_prev   = 8'h00;
        ra_on     = 1'b0;
        ra_addr   = 3'h0;
        tri_hi    = 1'b1;
        tri_lo    = 1'b0;
        rst       = 1'b1;
        repeat (3) @(negedge mclk);
        rst = 1'b0;
        // Bank A holds codes 0 to 7 and bank B 8 to f, so four views show every code.
        for (k = 0; k < 2; k++)
        begin
            host_u.put_byte(1'b1, ctl(1'b1, 1'b1, 1'b0, 1'b1, ~k[0], 3'h0));
            check(seq_active, 1'b1);
            for (i = 0; i < 8; i++)
            begin
                val[8*k+i] = byte_t'($random(seed)) & 8'hf0 | byte_t'(8*k+i);
                host_u.put_byte(1'b0, val[8*k+i]);
            end
            check(seq_active, 1'b0);
        end
        for (k = 0; k < 4; k++)
        begin
            host_u.put_byte(1'b1, ctl(1'b0, k[1], 1'b0, 1'b1, k[0], 3'h0));
            for (i = 0; i < 8; i++)
            begin
                v = val[i + (k[0] ? 0 : 8)];
                shown[i] = {v[7], k[1] ? HEX_T[v[3:0]] : CODEB_T[v[3:0]]};
            end
            scan_check();
        end
        host_u.put_byte(1'b1, ctl(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 3'h0));
        for (i = 0; i < 8; i++)
        begin
            shown[i] = byte_t'($random(seed));
            ra_addr  = i[2:0];
            host_u.put_byte(1'b0, shown[i]);
            ra_exp[i] = {shown[i][7], HEX_T[shown[i][3:0]]};
        end
        ra_on = 1'b1;
        scan_check();
        // Floating level on the three-level input selects Code B in the random-access copy.
        tri_hi = 1'b0;
        for (i = 0; i < 8; i++)
        begin
            ra_exp[i] = {shown[i][7], CODEB_T[shown[i][3:0]]};
        end
        scan_check();
        ra_on = 1'b0;
        for (k = 0; k < 3; k++)
        begin
            i = {$random(seed)} % 8;
            host_u.put_byte(1'b1, ctl(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, i[2:0]));
            shown[i] = byte_t'($random(seed));
            host_u.put_byte(1'b0, shown[i]);
        end
        scan_check();
        tri_lo = 1'b1;
        host_u.put_byte(1'b1, ctl(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 3'h0));
        repeat (2) @(negedge mclk);
        k = 0;
        i = 0;
        repeat (2500) @(negedge mclk)
        begin
            if (digit_drive !== 8'h00 || seg_out !== 7'h00 || decimal_point_out !== 1'b0)
                k++;
            if (ra_dd !== 8'h00 || ra_seg !== 7'h00 || ra_dp !== 1'b0)
                i++;
        end
        check(k, 0);
        check(i, 0);
        tri_lo = 1'b0;
        host_u.put_byte(1'b1, ctl(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 3'h0));
        scan_check();
        end_sim();
    end
endmodule : led_display_tb
